// ---- verilog/monitor_router_pkg.sv ----
/*
 Shared constants for the monitor output router: headphone source codes,
 slot list sizes, attenuation limits and monitor delay timing.
 Assumes a single audio sample clock domain.
*/
package monitor_router_pkg;
    localparam int SAMPLE_W = 24;
    localparam int PRESET_COUNT = 5;
    localparam int USER_SLOTS = 20;
    localparam int SLOT_IDX_W = 5;
    localparam int SRC_W = 4;
    localparam int ATTEN_W = 6;
    localparam logic [ATTEN_W-1:0] ATTEN_MAX_DB = 6'h28;
    localparam int DELAY_SECONDS = 12;
    localparam int RATE_HZ = 48000;
    localparam int MONITOR_DELAY_SAMPLES = DELAY_SECONDS * RATE_HZ;
    localparam int BUS_SEL_W = 3;

    // Headphone sources.
    localparam logic [SRC_W-1:0] HP_IN_STEREO = 4'h0;
    localparam logic [SRC_W-1:0] HP_TRK_STEREO = 4'h1;
    localparam logic [SRC_W-1:0] HP_MON_STEREO = 4'h2;
    localparam logic [SRC_W-1:0] HP_IN1_SOLO = 4'h3;
    localparam logic [SRC_W-1:0] HP_IN2_SOLO = 4'h4;
    localparam logic [SRC_W-1:0] HP_TRKA_SOLO = 4'h5;
    localparam logic [SRC_W-1:0] HP_TRKB_SOLO = 4'h6;
    localparam logic [SRC_W-1:0] HP_MONA_SOLO = 4'h7;
    localparam logic [SRC_W-1:0] HP_MONB_SOLO = 4'h8;
    localparam logic [SRC_W-1:0] HP_IN_MS = 4'h9;
    localparam logic [SRC_W-1:0] HP_TRK_MS = 4'ha;
    localparam logic [SRC_W-1:0] HP_MON_MS = 4'hb;
    localparam logic [SRC_W-1:0] HP_IN_SUM = 4'hc;
    localparam logic [SRC_W-1:0] HP_TRK_SUM = 4'hd;
    localparam logic [SRC_W-1:0] HP_SRC_LAST = 4'hd;

    // Digital bus per-side sources.
    localparam logic [BUS_SEL_W-1:0] BUS_IN1 = 3'h0;
    localparam logic [BUS_SEL_W-1:0] BUS_IN2 = 3'h1;
    localparam logic [BUS_SEL_W-1:0] BUS_TRKA = 3'h2;
    localparam logic [BUS_SEL_W-1:0] BUS_TRKB = 3'h3;
    localparam logic [BUS_SEL_W-1:0] BUS_IN_SUM = 3'h4;
    localparam logic [BUS_SEL_W-1:0] BUS_TRK_SUM = 3'h5;

    // Channel status byte 0 layout.
    localparam int CS_PRO_BIT = 0;
    localparam int CS_COPY_BIT = 2;
endpackage : monitor_router_pkg

// ---- verilog/skid_buffer.sv ----
/*
 Two-entry valid/ready buffer for one stereo sample word.
 Assumes the sink may stall at any cycle; no accepted word is lost.
*/
`timescale 1ns/1ps
module skid_buffer #(
    parameter int WIDTH = 48
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic rd_q, rd_d, wr_q, wr_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rd_q];

    always_comb begin
        push = ce && in_valid && in_ready;
        pop = ce && out_valid && out_ready;
        mem_d = mem_q;
        if (push) begin
            mem_d[wr_q] = in_data;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (ce) begin
            mem_q <= mem_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : skid_buffer

// ---- verilog/monitor_output_router.sv ----
/*
 Monitor output router: headphone source selection with slot list and
 configuration sequence, and the digital output bus with its own source
 assignment, attenuation and channel status format bits.
 Assumes inputs, tracks and playback arrive as one sample per sample_tick,
 and that the monitor stream is already delayed by the record buffer.
*/
`timescale 1ns/1ps
module monitor_output_router
    import monitor_router_pkg::*;
#(
    parameter int SW = SAMPLE_W,
    parameter int NUM_USER_SLOTS = USER_SLOTS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic sample_tick,
    input wire logic signed [SW-1:0] in1,
    input wire logic signed [SW-1:0] in2,
    input wire logic signed [SW-1:0] trk_a,
    input wire logic signed [SW-1:0] trk_b,
    input wire logic signed [SW-1:0] drive_a,
    input wire logic signed [SW-1:0] drive_b,
    input wire logic signed [SW-1:0] card_a,
    input wire logic signed [SW-1:0] card_b,
    input wire logic media_card_sel,
    input wire logic written_valid,
    input wire logic playing,
    input wire logic rotary_step,
    input wire logic rotary_dir,
    input wire logic cfg_start,
    input wire logic cfg_enter,
    input wire logic cfg_finish,
    input wire logic cfg_cancel,
    input wire logic [BUS_SEL_W-1:0] bus_sel_l,
    input wire logic [BUS_SEL_W-1:0] bus_sel_r,
    input wire logic [ATTEN_W-1:0] bus_atten_db,
    input wire logic bus_pro_format,
    output logic signed [SW-1:0] hp_l,
    output logic signed [SW-1:0] hp_r,
    output logic [SRC_W-1:0] hp_src,
    output logic cfg_active,
    output logic [SLOT_IDX_W-1:0] cfg_slot,
    output logic [SRC_W-1:0] cfg_pick,
    output logic aes_valid,
    input wire logic aes_ready,
    output logic signed [SW-1:0] aes_l,
    output logic signed [SW-1:0] aes_r,
    output logic [7:0] aes_cs_byte0
);
    typedef enum logic [0:0] {CFG_IDLE, CFG_EDIT} cfg_state_e;
    localparam int LIST_N = PRESET_COUNT + NUM_USER_SLOTS;
    localparam logic [SRC_W-1:0] PRESETS [PRESET_COUNT] =
        '{HP_IN_STEREO, HP_TRK_STEREO, HP_MON_STEREO, HP_IN_MS, HP_TRK_SUM};

    // Headphone list and configuration state.
    cfg_state_e st_q, st_d;
    logic [SRC_W-1:0] list_q [LIST_N];
    logic [SRC_W-1:0] list_d [LIST_N];
    logic [SRC_W-1:0] edit_q [NUM_USER_SLOTS];
    logic [SRC_W-1:0] edit_d [NUM_USER_SLOTS];
    logic [SLOT_IDX_W:0] len_q, len_d;
    logic [SLOT_IDX_W:0] pos_q, pos_d;
    logic [SLOT_IDX_W-1:0] slot_q, slot_d;
    logic [SRC_W-1:0] pick_q, pick_d;
    logic [SRC_W-1:0] pend_q, pend_d;
    logic [SRC_W-1:0] sel_q, sel_d;

    always_comb begin
        st_d = st_q;
        list_d = list_q;
        edit_d = edit_q;
        len_d = len_q;
        pos_d = pos_q;
        slot_d = slot_q;
        pick_d = pick_q;
        pend_d = pend_q;
        sel_d = sel_q;
        unique case (st_q)
            CFG_IDLE: begin
                if (cfg_start) begin
                    st_d = CFG_EDIT;
                    slot_d = '0;
                    pick_d = HP_IN_STEREO;
                end else if (rotary_step) begin
                    if (rotary_dir) begin
                        pos_d = (pos_q + 1'b1 >= len_q) ? '0 : pos_q + 1'b1;
                    end else begin
                        pos_d = (pos_q == '0) ? len_q - 1'b1 : pos_q - 1'b1;
                    end
                    pend_d = list_q[pos_d[SLOT_IDX_W-1:0]];
                end
            end
            CFG_EDIT: begin
                if (cfg_cancel) begin
                    st_d = CFG_IDLE;
                end else if (cfg_finish) begin
                    st_d = CFG_IDLE;
                    pos_d = '0;
                    if (slot_q == '0) begin
                        list_d[0] = HP_TRK_STEREO;
                        len_d = (SLOT_IDX_W+1)'(1);
                        pend_d = HP_TRK_STEREO;
                    end else begin
                        for (int i = 0; i < PRESET_COUNT; i++) begin
                            list_d[i] = PRESETS[i];
                        end
                        for (int i = 0; i < NUM_USER_SLOTS; i++) begin
                            if (i < int'(slot_q)) begin
                                list_d[PRESET_COUNT+i] = edit_q[i];
                            end
                        end
                        len_d = (SLOT_IDX_W+1)'(PRESET_COUNT) + {1'b0, slot_q};
                        pend_d = list_d[0];
                    end
                end else if (rotary_step) begin
                    if (rotary_dir) begin
                        pick_d = (pick_q == HP_SRC_LAST) ? '0 : pick_q + 1'b1;
                    end else begin
                        pick_d = (pick_q == '0) ? HP_SRC_LAST : pick_q - 1'b1;
                    end
                end else if (cfg_enter && int'(slot_q) < NUM_USER_SLOTS) begin
                    edit_d[slot_q] = pick_q;
                    slot_d = slot_q + 1'b1;
                end
            end
        endcase
        // A new choice waits in pend_q so that it lands between two samples.
        if (sample_tick) begin
            sel_d = pend_d;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= CFG_IDLE;
            for (int i = 0; i < LIST_N; i++) begin
                if (i < PRESET_COUNT) begin
                    list_q[i] <= PRESETS[i % PRESET_COUNT];
                end else begin
                    list_q[i] <= HP_IN_STEREO;
                end
            end
            for (int i = 0; i < NUM_USER_SLOTS; i++) begin
                edit_q[i] <= HP_IN_STEREO;
            end
            len_q <= (SLOT_IDX_W+1)'(PRESET_COUNT);
            pos_q <= '0;
            slot_q <= '0;
            pick_q <= HP_IN_STEREO;
            pend_q <= PRESETS[0];
            sel_q <= PRESETS[0];
        end else if (ce) begin
            st_q <= st_d;
            list_q <= list_d;
            edit_q <= edit_d;
            len_q <= len_d;
            pos_q <= pos_d;
            slot_q <= slot_d;
            pick_q <= pick_d;
            pend_q <= pend_d;
            sel_q <= sel_d;
        end
    end

    // Headphone mixing, independent of bus selections.
    logic signed [SW-1:0] mon_a, mon_b, src_a, src_b, mix_l, mix_r;
    logic signed [SW:0] wide_l, wide_r;
    logic signed [SW-1:0] hl_q, hr_q;
    logic signed [SW-1:0] hl_d, hr_d;
    logic mon_ok;

    function automatic logic signed [SW-1:0] half_sum(input logic signed [SW-1:0] a,
                                                      input logic signed [SW-1:0] b);
        logic signed [SW:0] s;
        s = {a[SW-1], a} + {b[SW-1], b};
        return s[SW:1];
    endfunction : half_sum

    always_comb begin
        mon_a = media_card_sel ? card_a : drive_a;
        mon_b = media_card_sel ? card_b : drive_b;
        mon_ok = playing && written_valid;
        src_a = playing ? mon_a : trk_a;
        src_b = playing ? mon_b : trk_b;
        mix_l = '0;
        mix_r = '0;
        wide_l = '0;
        wide_r = '0;
        unique case (sel_q)
            HP_IN_STEREO: begin mix_l = in1; mix_r = in2; end
            HP_TRK_STEREO: begin mix_l = src_a; mix_r = src_b; end
            HP_MON_STEREO: if (mon_ok) begin mix_l = mon_a; mix_r = mon_b; end
            HP_IN1_SOLO: begin mix_l = in1; mix_r = in1; end
            HP_IN2_SOLO: begin mix_l = in2; mix_r = in2; end
            HP_TRKA_SOLO: begin mix_l = src_a; mix_r = src_a; end
            HP_TRKB_SOLO: begin mix_l = src_b; mix_r = src_b; end
            HP_MONA_SOLO: if (mon_ok) begin mix_l = mon_a; mix_r = mon_a; end
            HP_MONB_SOLO: if (mon_ok) begin mix_l = mon_b; mix_r = mon_b; end
            HP_IN_MS: begin
                wide_l = {in1[SW-1], in1} + {in2[SW-1], in2};
                wide_r = {in1[SW-1], in1} - {in2[SW-1], in2};
                mix_l = wide_l[SW:1];
                mix_r = wide_r[SW:1];
            end
            HP_TRK_MS: begin
                wide_l = {src_a[SW-1], src_a} + {src_b[SW-1], src_b};
                wide_r = {src_a[SW-1], src_a} - {src_b[SW-1], src_b};
                mix_l = wide_l[SW:1];
                mix_r = wide_r[SW:1];
            end
            HP_MON_MS: if (mon_ok) begin
                wide_l = {mon_a[SW-1], mon_a} + {mon_b[SW-1], mon_b};
                wide_r = {mon_a[SW-1], mon_a} - {mon_b[SW-1], mon_b};
                mix_l = wide_l[SW:1];
                mix_r = wide_r[SW:1];
            end
            HP_IN_SUM: begin mix_l = half_sum(in1, in2); mix_r = mix_l; end
            HP_TRK_SUM: begin mix_l = half_sum(src_a, src_b); mix_r = mix_l; end
            default: begin mix_l = '0; mix_r = '0; end
        endcase
        hl_d = sample_tick ? mix_l : hl_q;
        hr_d = sample_tick ? mix_r : hr_q;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hl_q <= '0;
            hr_q <= '0;
        end else if (ce) begin
            hl_q <= hl_d;
            hr_q <= hr_d;
        end
    end

    // Digital bus, with its own source and attenuation settings.
    logic signed [SW-1:0] bus_l, bus_r;
    logic [ATTEN_W-1:0] att;
    logic in_ready;

    function automatic logic signed [SW-1:0] bus_pick(input logic [BUS_SEL_W-1:0] s,
                                                      input logic signed [SW-1:0] i1,
                                                      input logic signed [SW-1:0] i2,
                                                      input logic signed [SW-1:0] ta,
                                                      input logic signed [SW-1:0] tb);
        logic signed [SW-1:0] r;
        r = '0;
        unique case (s)
            BUS_IN1: r = i1;
            BUS_IN2: r = i2;
            BUS_TRKA: r = ta;
            BUS_TRKB: r = tb;
            BUS_IN_SUM: r = half_sum(i1, i2);
            BUS_TRK_SUM: r = half_sum(ta, tb);
            default: r = '0;
        endcase
        return r;
    endfunction : bus_pick

    // Approximate gain of 1 dB per step: each step scales by 57/64.
    function automatic logic signed [SW-1:0] attenuate(input logic signed [SW-1:0] x,
                                                       input logic [ATTEN_W-1:0] db);
        logic signed [SW+6:0] acc;
        acc = {{7{x[SW-1]}}, x};
        for (int i = 0; i < int'(ATTEN_MAX_DB); i++) begin
            if (i < int'(db)) begin
                acc = (SW+7)'((acc * 57) >>> 6);
            end
        end
        return acc[SW-1:0];
    endfunction : attenuate

    always_comb begin
        att = (bus_atten_db > ATTEN_MAX_DB) ? ATTEN_MAX_DB : bus_atten_db;
        bus_l = attenuate(bus_pick(bus_sel_l, in1, in2, src_a, src_b), att);
        bus_r = attenuate(bus_pick(bus_sel_r, in1, in2, src_a, src_b), att);
    end

    // The bus goes only to the serial output stream.
    // A full buffer drops the word of the next tick, so the receiver must keep up.
    skid_buffer #(
        .WIDTH(2*SW)
    ) u_aes_buf (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .in_valid(sample_tick),
        .in_ready(in_ready),
        .in_data({bus_l, bus_r}),
        .out_valid(aes_valid),
        .out_ready(aes_ready),
        .out_data({aes_l, aes_r})
    );

    always_comb begin
        aes_cs_byte0 = 8'h00;
        aes_cs_byte0[CS_PRO_BIT] = bus_pro_format;
        aes_cs_byte0[CS_COPY_BIT] = 1'b0;
    end

    assign hp_l = hl_q;
    assign hp_r = hr_q;
    assign hp_src = sel_q;
    assign cfg_active = (st_q == CFG_EDIT);
    assign cfg_slot = slot_q;
    assign cfg_pick = pick_q;
endmodule : monitor_output_router

// ---- testbench/monitor_output_router_properties.sv ----
/*
 Concurrent checks on the monitor output router ports.
 Assumes ce is held high and sample ticks come at least two cycles apart.
*/
`timescale 1ns/1ps
module monitor_output_router_checker
    import monitor_router_pkg::*;
#(
    parameter int SW = SAMPLE_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic sample_tick,
    input wire logic playing,
    input wire logic rotary_step,
    input wire logic cfg_start,
    input wire logic cfg_enter,
    input wire logic cfg_finish,
    input wire logic cfg_cancel,
    input wire logic bus_pro_format,
    input wire logic signed [SW-1:0] hp_l,
    input wire logic signed [SW-1:0] hp_r,
    input wire logic [SRC_W-1:0] hp_src,
    input wire logic cfg_active,
    input wire logic [SLOT_IDX_W-1:0] cfg_slot,
    input wire logic aes_valid,
    input wire logic aes_ready,
    input wire logic signed [SW-1:0] aes_l,
    input wire logic signed [SW-1:0] aes_r,
    input wire logic [7:0] aes_cs_byte0
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_settled;
        $past(sample_tick, 2) && hp_src == $past(hp_src, 3);
    endsequence

    property p_copy_clear;
        aes_cs_byte0[CS_COPY_BIT] == 1'b0;
    endproperty
    a_copy_clear: assert property (p_copy_clear) else $error("copy bit set");
    property p_pro_fmt;
        aes_cs_byte0[CS_PRO_BIT] == bus_pro_format;
    endproperty
    a_pro_fmt: assert property (p_pro_fmt) else $error("format bit wrong");
    property p_hp_hold;
        !$past(sample_tick) && !$past(sample_tick, 2) |-> $stable(hp_l) && $stable(hp_r);
    endproperty
    a_hp_hold: assert property (p_hp_hold) else $error("headphone moved off tick");
    property p_src_hold;
        $changed(hp_src) |-> $past(sample_tick);
    endproperty
    a_src_hold: assert property (p_src_hold) else $error("source moved off tick");
    property p_mono;
        s_settled ##0 hp_src inside {[4'h3:4'h8], 4'hc, 4'hd} |-> hp_l == hp_r;
    endproperty
    a_mono: assert property (p_mono) else $error("mono sides differ");
    property p_silent;
        s_settled ##0 hp_src inside {4'h2, 4'h7, 4'h8, 4'hb} && !$past(playing, 2) && !$past(playing, 3)
            |-> hp_l == '0 && hp_r == '0;
    endproperty
    a_silent: assert property (p_silent) else $error("monitor not silent");
    property p_cfg_open;
        cfg_start && !cfg_active && !cfg_cancel && !cfg_finish |=> cfg_active && cfg_slot == 5'h00;
    endproperty
    a_cfg_open: assert property (p_cfg_open) else $error("config did not open");
    property p_cfg_cancel;
        cfg_active && cfg_cancel |=> !cfg_active;
    endproperty
    a_cfg_cancel: assert property (p_cfg_cancel) else $error("cancel ignored");
    property p_cfg_enter;
        cfg_active && cfg_enter && !cfg_cancel && !cfg_finish && !rotary_step && cfg_slot < 5'h13
            |=> cfg_slot == $past(cfg_slot) + 5'h01;
    endproperty
    a_cfg_enter: assert property (p_cfg_enter) else $error("slot did not advance");
    property p_aes_hold;
        aes_valid && !aes_ready |=> aes_valid && $stable(aes_l) && $stable(aes_r);
    endproperty
    a_aes_hold: assert property (p_aes_hold) else $error("word lost in stall");
    property p_aes_rise;
        $rose(aes_valid) |-> $past(sample_tick);
    endproperty
    a_aes_rise: assert property (p_aes_rise) else $error("word without tick");

    c_finish: cover property (cfg_active && cfg_finish);
    c_stall: cover property (aes_valid && !aes_ready);
    c_ms_mon: cover property (hp_src == HP_MON_MS && $past(sample_tick));
endmodule : monitor_output_router_checker

bind monitor_output_router monitor_output_router_checker #(.SW(SW)) chk_i (.clk, .nrst, .sample_tick,
    .playing, .rotary_step, .cfg_start, .cfg_enter, .cfg_finish, .cfg_cancel, .bus_pro_format, .hp_l,
    .hp_r, .hp_src, .cfg_active, .cfg_slot, .aes_valid, .aes_ready, .aes_l, .aes_r, .aes_cs_byte0);

// ---- testbench/aes_receiver_model.sv ----
/*
 Digital output receiver: takes one stereo word per valid/ready handshake.
 Assumes the bench raises stall to hold the line off.
*/
`timescale 1ns/1ps
module aes_receiver_model
    import monitor_router_pkg::*;
#(
    parameter int SW = SAMPLE_W
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic stall,
    input wire logic aes_valid,
    output logic aes_ready,
    input wire logic [SW-1:0] aes_l,
    input wire logic [SW-1:0] aes_r
);
    logic [2*SW-1:0] got[$];

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aes_ready <= 1'b0;
        end else begin
            if (aes_valid && aes_ready) begin
                got.push_back({aes_l, aes_r});
            end
            aes_ready <= !stall;
        end
    end
endmodule : aes_receiver_model

// ---- testbench/tb.sv ----
/*
 Self-checking bench for the monitor output router.
 Assumes the receiver model on the digital bus and a 40 MHz clock.
*/
`timescale 1ns/1ps
module tb;
    import monitor_router_pkg::*;
    localparam logic [5:0] START = 6'h01, ENTER = 6'h02, FINISH = 6'h04, CANCEL = 6'h08, STEP = 6'h10;
    localparam logic [5:0] TICK = 6'h20;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, rotary_dir = 1'b1, stall = 1'b0;
    logic media_card_sel = 1'b0, written_valid = 1'b0, playing = 1'b0, bus_pro_format = 1'b0;
    logic [5:0] ev = 6'h00;
    logic [BUS_SEL_W-1:0] bus_sel_l = 3'h0, bus_sel_r = 3'h0;
    logic [ATTEN_W-1:0] bus_atten_db = 6'h00;
    logic signed [23:0] src [8];
    logic signed [23:0] hp_l, hp_r, aes_l, aes_r;
    logic [SRC_W-1:0] hp_src, cfg_pick;
    logic [SLOT_IDX_W-1:0] cfg_slot;
    logic cfg_active, aes_valid, aes_ready;
    logic [7:0] aes_cs_byte0;
    int fail_count = 0, comparisons = 0, cyc = 0;
    int at[3] = '{1, 40, 63}, lo[3] = '{'he0000, 'h2000, 'h2000}, hi[3] = '{'he8000, 'h4000, 'h4000};

    monitor_output_router uut (.clk, .nrst, .ce, .sample_tick(ev[5]), .in1(src[0]), .in2(src[1]),
        .trk_a(src[2]), .trk_b(src[3]), .drive_a(src[4]), .drive_b(src[5]), .card_a(src[6]),
        .card_b(src[7]), .media_card_sel, .written_valid, .playing, .rotary_step(ev[4]), .rotary_dir,
        .cfg_start(ev[0]), .cfg_enter(ev[1]), .cfg_finish(ev[2]), .cfg_cancel(ev[3]), .bus_sel_l,
        .bus_sel_r, .bus_atten_db, .bus_pro_format, .hp_l, .hp_r, .hp_src, .cfg_active, .cfg_slot,
        .cfg_pick, .aes_valid, .aes_ready, .aes_l, .aes_r, .aes_cs_byte0);
    aes_receiver_model rx (.clk, .nrst, .stall, .aes_valid, .aes_ready, .aes_l, .aes_r);

    initial begin
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            summarize();
        end
    end

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_rng(input logic [23:0] got, input int l, input int h);
        comparisons++;
        if ((got >= l && got <= h) !== 1'b1) begin
            fail_count++;
            $display("[ERR] %0t got %h exp %h..%h", $time, got, l, h);
        end
    endtask : chk_rng
    task automatic pulse(input logic [5:0] m);
        @(posedge clk) ev <= m;
        @(posedge clk) ev <= 6'h00;
        #1;
    endtask : pulse
    task automatic tk();
        pulse(TICK);
        pulse(TICK);
    endtask : tk
    task automatic set_src(input int o);
        for (int i = 0; i < 8; i++) src[i] <= 24'('h200 * (8 - i) + o);
    endtask : set_src
    function automatic int code(input int p);
        int pre[5] = '{0, 1, 2, 9, 13};
        return p < 5 ? pre[p] : p - 5;
    endfunction : code
    function automatic logic [47:0] hp_exp(input int c);
        int s[3][2];
        int a, b, k;
        k = media_card_sel ? 6 : 4;
        s[0][0] = src[0];
        s[0][1] = src[1];
        s[1][0] = playing ? src[k] : src[2];
        s[1][1] = playing ? src[k+1] : src[3];
        s[2][0] = (playing && written_valid) ? src[k] : 0;
        s[2][1] = (playing && written_valid) ? src[k+1] : 0;
        if (c < 3) begin
            a = s[c][0];
            b = s[c][1];
        end else if (c < 9) begin
            a = s[(c-3)/2][(c-3)%2];
            b = a;
        end else if (c < 12) begin
            a = (s[c-9][0] + s[c-9][1]) / 2;
            b = (s[c-9][0] - s[c-9][1]) / 2;
        end else begin
            a = (s[c-12][0] + s[c-12][1]) / 2;
            b = a;
        end
        return {a[23:0], b[23:0]};
    endfunction : hp_exp
    function automatic logic [23:0] bus_exp(input int k);
        int a;
        a = k < 4 ? src[k] : (src[2*k-8] + src[2*k-7]) / 2;
        return a[23:0];
    endfunction : bus_exp

    initial begin
        set_src(0);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk({hp_l, hp_r}, '0);
        chk({hp_src, cfg_active, aes_valid}, '0);
        pulse(START);
        chk(cfg_active, 1);
        pulse(STEP);
        chk(cfg_pick, HP_TRK_STEREO);
        pulse(ENTER);
        chk(cfg_slot, 1);
        pulse(CANCEL);
        chk(cfg_active, 0);
        pulse(STEP);
        tk();
        chk(hp_src, HP_TRK_STEREO);
        pulse(START);
        for (int k = 0; k < 14; k++) begin
            if (k > 0) pulse(STEP);
            pulse(ENTER);
        end
        chk(cfg_slot, 14);
        pulse(FINISH);
        for (int ps = 0; ps < 3; ps++) begin
            playing <= ps > 0;
            written_valid <= ps == 1;
            media_card_sel <= ps == 1;
            set_src(ps * 'h20);
            for (int p = 0; p < 19; p++) begin
                bus_sel_l <= p[2:0];
                if (p > 0) begin
                    pulse(STEP);
                    chk(hp_src, code(p - 1));
                end
                tk();
                chk(hp_src, code(p));
                chk({hp_l, hp_r}, hp_exp(code(p)));
            end
            pulse(STEP);
        end
        playing <= 1'b0;
        set_src(0);
        for (int k = 0; k < 6; k++) begin
            bus_sel_l <= k[2:0];
            bus_sel_r <= 3'(5 - k);
            pulse(TICK);
            repeat (2) @(posedge clk);
            #1;
            chk(rx.got[$], {bus_exp(k), bus_exp(5 - k)});
        end
        src[0] <= 24'h100000;
        bus_sel_l <= 3'h0;
        for (int i = 0; i < 3; i++) begin
            bus_atten_db <= 6'(at[i]);
            pulse(TICK);
            repeat (2) @(posedge clk);
            #1;
            chk_rng(rx.got[$][47:24], lo[i], hi[i]);
        end
        bus_atten_db <= 6'h00;
        bus_sel_r <= 3'h0;
        stall <= 1'b1;
        repeat (3) @(posedge clk);
        rx.got.delete();
        for (int i = 1; i < 4; i++) begin
            src[0] <= 24'(i * 'h11);
            pulse(TICK);
        end
        stall <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        chk(rx.got.size(), 2);
        chk(rx.got[0], {24'h11, 24'h11});
        chk(rx.got[1], {24'h22, 24'h22});
        for (int f = 0; f < 2; f++) begin
            bus_pro_format <= f[0];
            @(posedge clk);
            #1;
            chk({aes_cs_byte0[CS_PRO_BIT], aes_cs_byte0[CS_COPY_BIT]}, {f[0], 1'b0});
        end
        pulse(START);
        pulse(FINISH);
        tk();
        chk(hp_src, HP_TRK_STEREO);
        rotary_dir <= 1'b0;
        pulse(STEP);
        tk();
        chk(hp_src, HP_TRK_STEREO);
        summarize();
    end
endmodule : tb
